// *** rtl/ats_top.sv ***
`timescale 1ns/1ps
module ats_top
  import ats_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [31:0] STATE_IN,
  input  wire logic        STATE_STROBE,
  input  wire logic        INTERNAL_TRIGGER_LINE_ONE_I,
  output logic             INTERNAL_TRIGGER_LINE_ONE_O,
  output logic             INTERNAL_TRIGGER_LINE_ONE_OE,
  input  wire logic        INTERNAL_TRIGGER_LINE_TWO_I,
  output logic             INTERNAL_TRIGGER_LINE_TWO_O,
  output logic             INTERNAL_TRIGGER_LINE_TWO_OE,
  input  wire logic        X_TRIGGER_IN,
  output logic             X_COND_APPLY,
  output logic [15:0]      X_COND_COUNT,
  output logic             TRIGGERED,
  output logic             REC_VALID,
  output ats_rec_t         REC
);
  ////////////////////////////////////////////////////////////////////////////
  logic [35:0] sync_s;
  logic [31:0] state_s;
  logic        strb_s;
  logic        strb_d_r;
  logic        line1_s;
  logic        line2_s;
  logic        xtrig_s;
  logic        evt;

  ats_sync #(.W(36)) u_sync (
    .clk  (SYS_CLK),
    .rst  (RST),
    .din  ({X_TRIGGER_IN, INTERNAL_TRIGGER_LINE_TWO_I, INTERNAL_TRIGGER_LINE_ONE_I,
            STATE_STROBE, STATE_IN}),
    .dout (sync_s)
  );
  assign {xtrig_s, line2_s, line1_s, strb_s, state_s} = sync_s;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      strb_d_r <= 1'b0;
    end else begin
      strb_d_r <= strb_s;
    end
  end
  // One captured bus state per strobe rise
  assign evt = strb_s & ~strb_d_r;

  ////////////////////////////////////////////////////////////////////////////
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_go;
  logic        wr_ok;
  logic [31:0] wmask;

  logic [6:0]  ctrl_r;
  ats_qual_t   tg_q_r;
  ats_qual_t   p1_q_r;
  logic [15:0] p1_cnt_r;
  logic        p1_arm_r;
  ats_qual_t   el_q_r;
  logic [1:0]  else_en_r;
  ats_qual_t   sto_q_r;
  logic        x_apply_r;
  logic [15:0] x_cnt_r;

  logic        run_r;
  logic        trig_r;
  logic        armed_r;
  ats_term_t   term_r;
  logic [15:0] occ_r;
  logic [31:0] time_r;
  logic        oe1_r;
  logic        oe2_r;
  logic        rec_valid_r;
  ats_rec_t    rec_r;

  logic        cplx;
  logic        append;
  ats_out_t    out_sel;
  ats_arm_t    arm_sel;
  logic        tcs_go;
  logic [15:0] tcs_cnt;
  logic        start;

  assign cplx    = ctrl_r[CTRL_CPLX];
  assign append  = ctrl_r[CTRL_APP];
  assign out_sel = ats_out_t'(ctrl_r[CTRL_OUT +: 2]);
  assign arm_sel = ats_arm_t'(ctrl_r[CTRL_ARM +: 2]);

  assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign tcs_go = wr_go & (awaddr_r == OFS_TCS);
  // A zero count means none given
  assign tcs_cnt = (wdata_r[15:0] == 16'h0000) ? CNT_ONE : wdata_r[15:0];
  assign start = wr_go & (awaddr_r == OFS_CTRL) & wdata_r[CTRL_RUN] & wstrb_r[0] & ~run_r;

  always_comb begin
    case (awaddr_r)
      OFS_CTRL, OFS_TGVAL, OFS_TGMSK, OFS_TCS, OFS_ELVAL, OFS_ELMSK,
      OFS_ELCFG, OFS_STOVAL, OFS_STOMSK: wr_ok = 1'b1;
      OFS_XTCS: wr_ok = ~append;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Setup registers; a trigger set rewrites only sequencer terms
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r    <= CTRL_RST;
      tg_q_r    <= '0;
      p1_q_r    <= '0;
      p1_cnt_r  <= CNT_ONE;
      p1_arm_r  <= 1'b0;
      el_q_r    <= '0;
      else_en_r <= ELSE_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        OFS_CTRL: ctrl_r <= 7'((ctrl_r & wmask[6:0]) ^ ctrl_r ^ (wdata_r[6:0] & wmask[6:0]));
        OFS_TGVAL: tg_q_r.value <= (tg_q_r.value & ~wmask) | (wdata_r & wmask);
        OFS_TGMSK: tg_q_r.mask <= (tg_q_r.mask & ~wmask) | (wdata_r & wmask);
        OFS_ELVAL: el_q_r.value <= (el_q_r.value & ~wmask) | (wdata_r & wmask);
        OFS_ELMSK: el_q_r.mask <= (el_q_r.mask & ~wmask) | (wdata_r & wmask);
        OFS_ELCFG: else_en_r <= wdata_r[1:0];
        OFS_TCS: begin
          p1_q_r   <= tg_q_r;
          p1_cnt_r <= tcs_cnt;
          p1_arm_r <= wdata_r[TCS_ARM];
          if (cplx) begin
            else_en_r[1] <= 1'b0;
          end else begin
            else_en_r[0] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Kept apart so a trigger set cannot touch it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sto_q_r <= '0;
    end else if (wr_go & (awaddr_r == OFS_STOVAL)) begin
      sto_q_r.value <= (sto_q_r.value & ~wmask) | (wdata_r & wmask);
    end else if (wr_go & (awaddr_r == OFS_STOMSK)) begin
      sto_q_r.mask <= (sto_q_r.mask & ~wmask) | (wdata_r & wmask);
    end
  end

  // Second analyzer condition; appended it follows ours
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      x_apply_r <= 1'b0;
      x_cnt_r   <= CNT_ONE;
    end else begin
      x_apply_r <= 1'b0;
      if ((tcs_go & append) | (wr_go & wr_ok & (awaddr_r == OFS_XTCS))) begin
        x_apply_r <= 1'b1;
        x_cnt_r   <= tcs_cnt;
      end
    end
  end
  assign X_COND_APPLY = x_apply_r;
  assign X_COND_COUNT = x_cnt_r;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case ({S_AXI_ARADDR[7:2], 2'b00})
        OFS_CTRL:   rdata_r <= {25'h0, ctrl_r[6:1], run_r};
        OFS_TGVAL:  rdata_r <= tg_q_r.value;
        OFS_TGMSK:  rdata_r <= tg_q_r.mask;
        OFS_TCS:    rdata_r <= {15'h0, p1_arm_r, p1_cnt_r};
        OFS_ELVAL:  rdata_r <= el_q_r.value;
        OFS_ELMSK:  rdata_r <= el_q_r.mask;
        OFS_ELCFG:  rdata_r <= {30'h0, else_en_r};
        OFS_STOVAL: rdata_r <= sto_q_r.value;
        OFS_STOMSK: rdata_r <= sto_q_r.mask;
        OFS_STATUS: rdata_r <= {occ_r, 12'h0, term_r == TERM_TWO, armed_r, trig_r, run_r};
        OFS_XTCS:   rdata_r <= {16'h0, x_cnt_r};
        default: begin
          rdata_r <= 32'h00000000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic pm;
  logic sm;
  logic hit;
  logic arm_line;
  logic branch;

  assign arm_line = (arm_sel == ARM_ONE) ? line1_s : (arm_sel == ARM_TWO) ? line2_s : 1'b0;
  assign pm  = ((state_s ^ p1_q_r.value) & p1_q_r.mask) == 32'h0 & (~p1_arm_r | armed_r);
  assign sm  = ((state_s ^ el_q_r.value) & el_q_r.mask) == 32'h0;
  assign hit = pm & ({1'b0, occ_r} + 17'h00001 >= {1'b0, p1_cnt_r});
  assign branch = evt & run_r & ((term_r == TERM_ONE) ? (hit & cplx) : (sm & else_en_r[1]));

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      run_r <= 1'b0;
    end else if (wr_go & (awaddr_r == OFS_CTRL) & wstrb_r[0]) begin
      run_r <= wdata_r[CTRL_RUN];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      armed_r <= 1'b0;
    end else if (start) begin
      armed_r <= 1'b0;
    end else if (run_r & arm_line) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      term_r <= TERM_ONE;
      occ_r  <= 16'h0000;
      trig_r <= 1'b0;
    end else if (start) begin
      term_r <= TERM_ONE;
      occ_r  <= 16'h0000;
      trig_r <= 1'b0;
    end else if (evt & run_r) begin
      case (term_r)
        TERM_ONE: begin
          if (hit) begin
            occ_r  <= 16'h0000;
            trig_r <= 1'b1;
            if (cplx) begin
              term_r <= TERM_TWO;
            end
          end else if (pm) begin
            occ_r <= occ_r + 16'h0001;
          end else if (sm & else_en_r[0]) begin
            occ_r <= 16'h0000;
          end
        end
        TERM_TWO: begin
          if (sm & else_en_r[1]) begin
            term_r <= TERM_ONE;
            occ_r  <= 16'h0000;
          end
        end
        default: term_r <= TERM_ONE;
      endcase
    end
  end
  assign TRIGGERED = trig_r;

  // Level outputs: they fall when the trace halts
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      oe1_r <= 1'b0;
      oe2_r <= 1'b0;
    end else begin
      oe1_r <= run_r & (trig_r | (append & xtrig_s)) & out_sel[0] & (arm_sel != ARM_ONE);
      oe2_r <= run_r & (trig_r | (append & xtrig_s)) & out_sel[1] & (arm_sel != ARM_TWO);
    end
  end
  assign INTERNAL_TRIGGER_LINE_ONE_OE = oe1_r;
  assign INTERNAL_TRIGGER_LINE_ONE_O  = oe1_r;
  assign INTERNAL_TRIGGER_LINE_TWO_OE = oe2_r;
  assign INTERNAL_TRIGGER_LINE_TWO_O  = oe2_r;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      time_r      <= 32'h00000000;
      rec_valid_r <= 1'b0;
      rec_r       <= '0;
    end else begin
      rec_valid_r <= 1'b0;
      if (start) begin
        time_r <= 32'h00000000;
      end else if (run_r & evt & (((state_s ^ sto_q_r.value) & sto_q_r.mask) == 32'h0)) begin
        rec_valid_r  <= 1'b1;
        rec_r.branch <= branch;
        rec_r.state  <= state_s;
        rec_r.delta  <= time_r;
        time_r       <= 32'h00000001;
      end else if (run_r) begin
        time_r <= time_r + 32'h00000001;
      end
    end
  end
  assign REC_VALID = rec_valid_r;
  assign REC       = rec_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_tcs_cplx;
    tcs_go && cplx;
  endsequence

  a_tcs_simple: assert property (tcs_go && !cplx |=> !else_en_r[0])
    else $error("restart qualifier not cleared");
  a_tcs_complex: assert property (s_tcs_cplx |=> !else_en_r[1] && p1_q_r == $past(tg_q_r))
    else $error("complex trigger set wrong");
  a_count_default: assert property (tcs_go && wdata_r[15:0] == 16'h0 |=> p1_cnt_r == 16'h1)
    else $error("zero count not taken as one");
  a_trig_cause: assert property ($rose(trig_r) |-> $past(hit && evt && term_r == TERM_ONE))
    else $error("trigger without count reached");
  a_arm_wait: assert property ($rose(trig_r) |-> $past(!p1_arm_r || armed_r))
    else $error("trigger before arm");
  a_halt_quiet: assert property (!run_r ##1 !run_r |-> !oe1_r && !oe2_r)
    else $error("line driven while halted");
  a_arm_line: assert property ($past(arm_sel == ARM_ONE) |-> !oe1_r)
    else $error("arm source line driven");
  a_prim_first: assert property (evt && run_r && term_r == TERM_ONE && pm && !hit && sm
                                 && !start |=> occ_r == $past(occ_r) + 16'h1)
    else $error("secondary beat primary");
  a_else_clear: assert property (evt && run_r && term_r == TERM_ONE && !pm && sm
                                 && else_en_r[0] && !start |=> occ_r == 16'h0)
    else $error("counter not cleared");
  a_cplx_enter: assert property (evt && run_r && term_r == TERM_ONE && hit && cplx
                                 && !start |=> term_r == TERM_TWO && trig_r)
    else $error("no entry into term two");
endmodule

// *** common/ats_pkg.sv ***
// Contract
// - Occurrence counts span 1 through 65535.
// - Unprogrammed count behaves as one.
// - Trigger after expression matched count times.
// - Simple mode: one term, trigger on exit.
// - Simple mode: restart qualifier set never.
// - Complex mode: trigger on entering term two.
// - Complex mode: term two secondary never.
// - Complex: term one primary, target two.
// - Trigger set leaves storage qualifier alone.
// - Arm-referencing expression waits for arm.
// - Reset selection drives no trigger line.
// - Arm source line never driven, silently.
// - Appended: either analyzer trigger drives lines.
// - Appended: shared condition, second setting refused.
// - Each stored state carries branch flag.
// - Each stored state carries time count.
// - Halted trace drives no trigger line.
// - Primary wins over simultaneous secondary.
// - Early secondary branch clears occurrence counter.
package ats_pkg;
  localparam int unsigned ATS_DW = 32;
  localparam int unsigned ATS_AW = 8;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TGVAL  = 8'h04;
  localparam logic [7:0] OFS_TGMSK  = 8'h08;
  localparam logic [7:0] OFS_TCS    = 8'h0C;
  localparam logic [7:0] OFS_ELVAL  = 8'h10;
  localparam logic [7:0] OFS_ELMSK  = 8'h14;
  localparam logic [7:0] OFS_ELCFG  = 8'h18;
  localparam logic [7:0] OFS_STOVAL = 8'h1C;
  localparam logic [7:0] OFS_STOMSK = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_XTCS   = 8'h28;

  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_CPLX = 1;
  localparam int unsigned CTRL_OUT  = 2;
  localparam int unsigned CTRL_ARM  = 4;
  localparam int unsigned CTRL_APP  = 6;
  localparam int unsigned TCS_ARM   = 16;

  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [1:0]  ELSE_RST  = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] value;
    logic [31:0] mask;
  } ats_qual_t;

  typedef struct packed {
    logic        branch;
    logic [31:0] state;
    logic [31:0] delta;
  } ats_rec_t;

  typedef enum logic {TERM_ONE, TERM_TWO} ats_term_t;
  typedef enum logic [1:0] {OUT_NONE, OUT_ONE, OUT_TWO, OUT_BOTH} ats_out_t;
  typedef enum logic [1:0] {ARM_NONE, ARM_ONE, ARM_TWO, ARM_RSVD} ats_arm_t;
endpackage

// *** rtl/ats_sync.sv ***
`timescale 1ns/1ps
module ats_sync
  import ats_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_chk
    $error("ats_sync width must be at least one");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    // A change counts once the last two stages agree
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1_r[i] <= din[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// *** verif/ats_far.sv ***
`timescale 1ns/1ps
module ats_far
  import ats_pkg::*;
(
  input  wire logic        clk,
  output logic      [31:0] st,
  output logic             stb,
  output logic             xtrig,
  output logic             arm_one,
  output logic             arm_two
);
  initial begin
    st = 32'h0000_0000;
    stb = 1'b0;
    xtrig = 1'b0;
    arm_one = 1'b0;
    arm_two = 1'b0;
  end

  // One bus state every 16 cycles; pins pass a 4-flop sync, so hold wide
  task automatic send(input logic [31:0] v);
    st <= v;
    repeat (2) @(posedge clk);
    stb <= 1'b1;
    repeat (6) @(posedge clk);
    stb <= 1'b0;
    repeat (4) @(posedge clk);
    // Stale bus shows the inverse, never a held copy
    st <= ~v;
    repeat (4) @(posedge clk);
  endtask

  // Second analyzer trigger and arm sources on the shared lines
  task automatic lines(input logic x, input logic a1, input logic a2);
    xtrig <= x;
    arm_one <= a1;
    arm_two <= a2;
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb
  import ats_pkg::*;
();
  typedef struct packed {
    logic cx; logic [15:0] cnt; logic [1:0] out; logic e1; logic e2;
  } ats_row_t;
  ats_row_t rows [4] = '{'{1'b0, 16'h0000, 2'h0, 1'b0, 1'b0},
                         '{1'b0, 16'h0001, 2'h1, 1'b1, 1'b0},
                         '{1'b0, 16'h0003, 2'h2, 1'b0, 1'b1},
                         '{1'b1, 16'h0002, 2'h3, 1'b1, 1'b1}};
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, st, d;
  logic        awready, wready, arready, bvalid, rvalid, stb, xtrig, far1, far2;
  logic [1:0]  bresp, rresp, rr;
  logic [3:0]  wstrb;
  logic        o1, oe1, o2, oe2, capply, trig, rvld;
  logic [15:0] xcnt, app_cnt;
  ats_rec_t    rec, rec_last, rec_prev;
  wire logic   line1 = oe1 ? o1 : far1;
  wire logic   line2 = oe2 ? o2 : far2;
  int          n_fail, checks_done, n_app, a0, n;

  ats_top u_ats_top (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .STATE_IN(st), .STATE_STROBE(stb), .INTERNAL_TRIGGER_LINE_ONE_I(line1),
    .INTERNAL_TRIGGER_LINE_ONE_O(o1), .INTERNAL_TRIGGER_LINE_ONE_OE(oe1),
    .INTERNAL_TRIGGER_LINE_TWO_I(line2), .INTERNAL_TRIGGER_LINE_TWO_O(o2),
    .INTERNAL_TRIGGER_LINE_TWO_OE(oe2), .X_TRIGGER_IN(xtrig), .X_COND_APPLY(capply),
    .X_COND_COUNT(xcnt), .TRIGGERED(trig), .REC_VALID(rvld), .REC(rec));
  ats_far u_ats_far (.clk(clk), .st(st), .stb(stb), .xtrig(xtrig), .arm_one(far1),
    .arm_two(far2));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses sampled mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (rvld === 1'b1) begin
      rec_prev <= rec_last;
      rec_last <= rec;
    end
    if (capply === 1'b1) begin
      n_app <= n_app + 1;
      app_cnt <= xcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'h0;
    // One idle edge so back-to-back calls never drive a strobe twice per step
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 50 && !b; i++) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b) begin
      n_fail++;
      close_out;
    end
    chk(32'(r), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar, got;
    got = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge clk);
      ar = arvalid && arready;
      got = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!got) begin
      n_fail++;
      close_out;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0; checks_done = 0; n_app = 0;
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({oe1, oe2}), 32'h0, "oe after reset");
    chk(32'(xcnt), 32'h1, "x count reset");
    rd(OFS_CTRL, d, rr);
    chk(d, 32'h0, "ctrl reset");
    rd(8'h3C, d, rr);
    chk({d[29:0], rr}, {30'h0, RESP_SLVERR}, "unmapped");
    wr(OFS_TGVAL, 32'h0000_0055, RESP_OKAY);
    wr(OFS_TGMSK, 32'h0000_00FF, RESP_OKAY);
    wr(OFS_ELVAL, 32'h0000_00AA, RESP_OKAY);
    wr(OFS_ELMSK, 32'h0000_00FF, RESP_OKAY);
    wr(OFS_STOVAL, 32'h1234_5678, RESP_OKAY);
    wr(OFS_STOMSK, 32'h0000_0000, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, (32'(rows[k].out) << 2) | (32'(rows[k].cx) << 1), RESP_OKAY);
      wr(OFS_ELCFG, 32'h3, RESP_OKAY);
      wr(OFS_TCS, 32'(rows[k].cnt), RESP_OKAY);
      rd(OFS_ELCFG, d, rr);
      chk(d & 32'h3, rows[k].cx ? 32'h1 : 32'h2, "elcfg");
      wr(OFS_CTRL, (32'(rows[k].out) << 2) | (32'(rows[k].cx) << 1) | 32'h1, RESP_OKAY);
      n = (rows[k].cnt == 16'h0) ? 1 : int'(rows[k].cnt);
      u_ats_far.send(32'h0000_00AA);
      for (int j = 1; j < n; j++) u_ats_far.send(32'h0000_1255);
      chk(32'(trig), 32'h0, "early trigger");
      u_ats_far.send(32'h0000_3455);
      chk(32'(trig), 32'h1, "no trigger");
      chk(32'({oe1, oe2}), 32'({rows[k].e1, rows[k].e2}), "lines");
      rd(OFS_STATUS, d, rr);
      chk(32'(d[3]), 32'(rows[k].cx), "term");
      chk(rec_last.state, 32'h0000_3455, "stored");
      chk(rec_last.delta, 32'd16, "delta");
      if (rows[k].cx) chk(32'({rec_prev.branch, rec_last.branch}), 32'h1, "br");
    end
    // Secondary matches every state here, primary only the 0x55 ones: primary must win
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_TCS, 32'h3, RESP_OKAY);
    wr(OFS_ELCFG, 32'h1, RESP_OKAY);
    wr(OFS_ELMSK, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_STATUS, d, rr);
    chk(32'(d[31:16]), 32'h0, "occ at start");
    u_ats_far.send(32'h0000_0055);
    u_ats_far.send(32'h0000_0055);
    rd(OFS_STATUS, d, rr);
    chk(32'(d[31:16]), 32'h2, "occ primary");
    u_ats_far.send(32'h0000_00AA);
    rd(OFS_STATUS, d, rr);
    chk(32'({d[31:16], trig}), 32'h0, "occ restart");
    rd(OFS_STOVAL, d, rr);
    chk(d, 32'h1234_5678, "storage kept");
    // Arm from line one, output selected on both lines, driven on line two only
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_TCS, 32'h0001_0001, RESP_OKAY);
    wr(OFS_CTRL, 32'h1D, RESP_OKAY);
    u_ats_far.send(32'h0000_0055);
    chk(32'(trig), 32'h0, "unarmed");
    u_ats_far.lines(1'b0, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    u_ats_far.send(32'h0000_0055);
    chk(32'(trig), 32'h1, "armed");
    chk(32'({oe1, oe2}), 32'h1, "arm line");
    wr(OFS_CTRL, 32'h1C, RESP_OKAY);
    // Line enables are registered: look once the halting edge has settled
    @(negedge clk);
    chk(32'({oe1, oe2}), 32'h0, "halted");
    @(posedge clk);
    // Complex mode armed from line two; term two leaves on secondary
    wr(OFS_CTRL, 32'h2E, RESP_OKAY);
    wr(OFS_TCS, 32'h0001_0001, RESP_OKAY);
    wr(OFS_ELCFG, 32'h2, RESP_OKAY);
    u_ats_far.lines(1'b0, 1'b0, 1'b1);
    wstrb <= 4'hE;
    wr(OFS_CTRL, 32'h2F, RESP_OKAY);
    rd(OFS_CTRL, d, rr);
    chk(d, 32'h2E, "masked lane");
    wstrb <= 4'hF;
    wr(OFS_CTRL, 32'h2F, RESP_OKAY);
    u_ats_far.send(32'h0000_0055);
    rd(OFS_STATUS, d, rr);
    chk(32'({d[3], d[1], oe1, oe2}), 32'hE, "arm two");
    u_ats_far.send(32'h0000_0055);
    rd(OFS_STATUS, d, rr);
    chk(32'({d[3], rec_last.branch}), 32'h1, "term two exit");
    // Appended second analyzer
    u_ats_far.lines(1'b1, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h44, RESP_OKAY);
    wr(OFS_CTRL, 32'h45, RESP_OKAY);
    repeat (6) @(posedge clk);
    chk(32'({oe1, oe2, trig}), 32'h4, "x trigger");
    wr(OFS_XTCS, 32'h7, RESP_SLVERR);
    a0 = n_app;
    wr(OFS_TCS, 32'h5, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(n_app - a0), 32'h1, "apply");
    chk(32'(app_cnt), 32'h5, "x count");
    // Reset in mid-run while a line is driven
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({oe1, oe2, trig, capply, bvalid, rvalid}), 32'h0, "mid reset");
    chk(32'(xcnt), 32'h1, "x count mid reset");
    @(posedge clk);
    rd(OFS_CTRL, d, rr);
    chk(d, 32'h0, "ctrl mid reset");
    close_out;
  end
endmodule
